// ---- pkg/buck_fault_pkg.sv ----
package buck_fault_pkg;

   // ****************************************************
   // Register map (byte addresses, one word each)
   // ****************************************************
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_UV_LEVEL = 8'h00;
   localparam logic [7:0]  OFS_OC_CTRL  = 8'h04;
   localparam logic [7:0]  OFS_AC_GAIN  = 8'h08;
   localparam logic [7:0]  OFS_DC_GAIN  = 8'h0C;
   localparam logic [7:0]  OFS_FLAGS    = 8'h10;

   // Register selector codes
   localparam logic [2:0]  SEL_UV       = 3'h0;
   localparam logic [2:0]  SEL_OC       = 3'h1;
   localparam logic [2:0]  SEL_AC       = 3'h2;
   localparam logic [2:0]  SEL_DC       = 3'h3;
   localparam logic [2:0]  SEL_FLAGS    = 3'h4;
   localparam logic [2:0]  SEL_NONE     = 3'h7;

   // ****************************************************
   // Field layout
   // ****************************************************
   localparam int          EN_BIT       = 7;
   localparam int          UV_THR_LSB   = 0;
   localparam int          OC_THR_LSB   = 0;
   localparam int          BLANK_LSB    = 5;
   localparam int          AC_GAIN_LSB  = 0;
   localparam int          DC_GAIN_LSB  = 0;
   localparam int          FLAG_UV_BIT  = 0;
   localparam int          FLAG_OC_BIT  = 1;
   localparam int          FLAG_DRV_BIT = 2;

   // Writable bits; others read as zero
   localparam logic [7:0]  WMASK_UV     = 8'hBF;
   localparam logic [7:0]  WMASK_OC     = 8'hFF;
   localparam logic [7:0]  WMASK_AC     = 8'h7F;
   localparam logic [7:0]  WMASK_DC     = 8'h8F;
   localparam logic [7:0]  RST_CFG      = 8'h00;

   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   localparam logic        HRESP_OKAY   = 1'b0;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int          CLK_KHZ      = 20000;
   localparam int          BLANK0_NS    = 114;
   localparam int          BLANK1_NS    = 213;
   localparam int          BLANK2_NS    = 400;
   localparam int          BLANK3_NS    = 780;
   localparam int          CNT_W        = 5;
   localparam int BLANK0_CYC = (BLANK0_NS * CLK_KHZ + 999_999) / 1_000_000;
   localparam int BLANK1_CYC = (BLANK1_NS * CLK_KHZ + 999_999) / 1_000_000;
   localparam int BLANK2_CYC = (BLANK2_NS * CLK_KHZ + 999_999) / 1_000_000;
   localparam int BLANK3_CYC = (BLANK3_NS * CLK_KHZ + 999_999) / 1_000_000;

   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [1:0] {
      DRV_OFF   = 2'b00,
      DRV_BLANK = 2'b01,
      DRV_SENSE = 2'b10,
      DRV_TERM  = 2'b11
   } drive_state_type;

   typedef struct packed {
      logic       uv_enable;
      logic [5:0] uv_threshold;
      logic       oc_enable;
      logic [1:0] blanking_select;
      logic [4:0] oc_threshold;
      logic [2:0] ac_reserved;
      logic [3:0] ac_gain_select;
      logic       dc_gain_route;
      logic       dc_reserved;
      logic [2:0] dc_gain_select;
   } analog_cfg_type;

endpackage

// ---- src/buck_fault_sense_config.sv ----
`timescale 1ns/100ps
module buck_fault_sense_config
   import buck_fault_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_clk_en,
   // AHB-Lite slave
   input  wire logic                 i_hsel,
   input  wire logic [ADDR_W-1:0]    i_haddr,
   input  wire logic [1:0]           i_htrans,
   input  wire logic                 i_hwrite,
   input  wire logic [2:0]           i_hsize,
   input  wire logic [31:0]          i_hwdata,
   input  wire logic                 i_hready,
   output logic      [31:0]          o_hrdata,
   output logic                      o_hreadyout,
   output logic                      o_hresp,
   // Analog comparators and modulator
   input  wire logic                 i_vin_below,
   input  wire logic                 i_oc_trip,
   input  wire logic                 i_pwm_req,
   // Analog settings, drive and fault flags
   output analog_cfg_type            o_cfg,
   output logic                      o_hs_drive,
   output logic                      o_input_low_flag,
   output logic                      o_overcurrent_flag
);

   // ****************************************************
   // State
   // ****************************************************
   localparam int SYN_UV  = 0;
   localparam int SYN_OC  = 1;
   localparam int SYN_PWM = 2;

   typedef struct packed {
      logic [2:0]       sync1;
      logic [2:0]       sync2;
      logic             pwm_d;
      logic [7:0]       uvl;
      logic [7:0]       occ;
      logic [7:0]       acg;
      logic [7:0]       dcg;
      logic             uv_flag;
      logic             oc_flag;
      logic             cyc_oc;
      logic             clean;
      drive_state_type  state;
      logic [CNT_W-1:0] cnt;
      logic             drive;
      logic             wr_pend;
      logic [2:0]       wr_sel;
      logic [31:0]      hrdata;
      logic             hreadyout;
      logic             hresp;
   } state_type;

   localparam state_type STATE_RST = '{
      sync1     : 3'h0,
      sync2     : 3'h0,
      pwm_d     : 1'b0,
      uvl       : RST_CFG,
      occ       : RST_CFG,
      acg       : RST_CFG,
      dcg       : RST_CFG,
      uv_flag   : 1'b0,
      oc_flag   : 1'b0,
      cyc_oc    : 1'b0,
      clean     : 1'b0,
      state     : DRV_OFF,
      cnt       : '0,
      drive     : 1'b0,
      wr_pend   : 1'b0,
      wr_sel    : SEL_NONE,
      hrdata    : 32'h0000_0000,
      hreadyout : 1'b1,
      hresp     : HRESP_OKAY
   };

   state_type state_reg;
   state_type state_next;
   logic      pwm_rise;
   logic      pwm_low;
   logic      oc_hit;
   logic      oc_event;
   logic      wr_flag_clr;
   logic [7:0] rd_byte;

   // ****************************************************
   // Decoders
   // ****************************************************
   function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [2:0] s;
      s = SEL_NONE;
      if (a == OFS_UV_LEVEL) begin
         s = SEL_UV;
      end else if (a == OFS_OC_CTRL) begin
         s = SEL_OC;
      end else if (a == OFS_AC_GAIN) begin
         s = SEL_AC;
      end else if (a == OFS_DC_GAIN) begin
         s = SEL_DC;
      end else if (a == OFS_FLAGS) begin
         s = SEL_FLAGS;
      end
      return s;
   endfunction

   function automatic logic [CNT_W-1:0] blank_cycles(input logic [1:0] sel);
      logic [CNT_W-1:0] c;
      unique case (sel)
         2'b00: c = CNT_W'(BLANK0_CYC);
         2'b01: c = CNT_W'(BLANK1_CYC);
         2'b10: c = CNT_W'(BLANK2_CYC);
         2'b11: c = CNT_W'(BLANK3_CYC);
      endcase
      return c;
   endfunction

   // ****************************************************
   // Next-state logic
   // ****************************************************
   always_comb begin
      state_next  = state_reg;
      oc_event    = 1'b0;
      wr_flag_clr = 1'b0;
      rd_byte     = 8'h00;

      // Two-stage synchronisers for all analog inputs
      state_next.sync1 = {i_pwm_req, i_oc_trip, i_vin_below};
      state_next.sync2 = state_reg.sync1;
      state_next.pwm_d = state_reg.sync2[SYN_PWM];

      pwm_rise = state_reg.sync2[SYN_PWM] & ~state_reg.pwm_d;
      pwm_low  = ~state_reg.sync2[SYN_PWM];
      oc_hit   = state_reg.occ[EN_BIT] & state_reg.sync2[SYN_OC];

      // Bus data phase: store masked write data
      if (state_reg.wr_pend) begin
         unique case (state_reg.wr_sel)
            SEL_UV: begin
               state_next.uvl = i_hwdata[7:0] & WMASK_UV;
            end
            SEL_OC: begin
               state_next.occ = i_hwdata[7:0] & WMASK_OC;
            end
            SEL_AC: begin
               state_next.acg = i_hwdata[7:0] & WMASK_AC;
            end
            SEL_DC: begin
               state_next.dcg = i_hwdata[7:0] & WMASK_DC;
            end
            SEL_FLAGS: begin
               wr_flag_clr = i_hwdata[FLAG_OC_BIT];
            end
            default: begin
               wr_flag_clr = 1'b0;
            end
         endcase
      end

      // Read mux of the current register contents
      unique case (reg_sel(i_haddr))
         SEL_UV:    rd_byte = state_reg.uvl;
         SEL_OC:    rd_byte = state_reg.occ;
         SEL_AC:    rd_byte = state_reg.acg;
         SEL_DC:    rd_byte = state_reg.dcg;
         SEL_FLAGS: begin
            rd_byte[FLAG_UV_BIT]  = state_reg.uv_flag;
            rd_byte[FLAG_OC_BIT]  = state_reg.oc_flag;
            rd_byte[FLAG_DRV_BIT] = state_reg.drive;
         end
         default:   rd_byte = 8'h00;
      endcase

      // Bus address phase
      state_next.wr_pend = 1'b0;
      if (i_hsel && i_htrans[1] && i_hready) begin
         state_next.wr_pend = i_hwrite && (i_hsize == HSIZE_WORD);
         state_next.wr_sel  = reg_sel(i_haddr);
         state_next.hrdata  = {24'h00_0000, rd_byte};
      end

      // High-side drive sequencing
      unique case (state_reg.state)
         DRV_OFF, DRV_TERM: begin
            if (pwm_rise) begin
               state_next.state = DRV_BLANK;
               state_next.cnt   = blank_cycles(
                  state_reg.occ[BLANK_LSB +: 2]);
               if (!state_reg.cyc_oc) begin
                  state_next.clean = 1'b1;
               end
               state_next.cyc_oc = 1'b0;
            end
         end
         DRV_BLANK: begin
            if (pwm_low) begin
               state_next.state = DRV_OFF;
            end else if (state_reg.cnt <= CNT_W'(1)) begin
               state_next.state = DRV_SENSE;
            end else begin
               state_next.cnt = state_reg.cnt - CNT_W'(1);
            end
         end
         DRV_SENSE: begin
            if (pwm_low) begin
               state_next.state = DRV_OFF;
            end else if (oc_hit) begin
               state_next.state = DRV_TERM;
               oc_event         = 1'b1;
            end
         end
      endcase

      if (oc_event) begin
         state_next.cyc_oc = 1'b1;
         state_next.clean  = 1'b0;
      end

      state_next.drive = (state_next.state == DRV_BLANK) ||
                         (state_next.state == DRV_SENSE);

      // Set wins over clear; clear needs a clean cycle
      state_next.oc_flag = oc_event | (state_reg.oc_flag &
         ~(wr_flag_clr & state_reg.clean));

      // Level-following flag, no software clear needed
      state_next.uv_flag = state_reg.uvl[EN_BIT] &
                           state_reg.sync2[SYN_UV];

      state_next.hreadyout = 1'b1;
      state_next.hresp     = HRESP_OKAY;
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_reg <= STATE_RST;
      end else if (i_clk_en) begin
         state_reg <= state_next;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign o_hrdata           = state_reg.hrdata;
   assign o_hreadyout        = state_reg.hreadyout;
   assign o_hresp            = state_reg.hresp;
   assign o_hs_drive         = state_reg.drive;
   assign o_input_low_flag   = state_reg.uv_flag;
   assign o_overcurrent_flag = state_reg.oc_flag;

   assign o_cfg.uv_enable       = state_reg.uvl[EN_BIT];
   assign o_cfg.uv_threshold    = state_reg.uvl[UV_THR_LSB +: 6];
   assign o_cfg.oc_enable       = state_reg.occ[EN_BIT];
   assign o_cfg.blanking_select = state_reg.occ[BLANK_LSB +: 2];
   assign o_cfg.oc_threshold    = state_reg.occ[OC_THR_LSB +: 5];
   assign o_cfg.ac_reserved     = state_reg.acg[6:4];
   assign o_cfg.ac_gain_select  = state_reg.acg[AC_GAIN_LSB +: 4];
   assign o_cfg.dc_gain_route   = state_reg.dcg[EN_BIT];
   assign o_cfg.dc_reserved     = state_reg.dcg[3];
   assign o_cfg.dc_gain_select  = state_reg.dcg[DC_GAIN_LSB +: 3];

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   a_uv_flag_set: assert property (
      i_clk_en && state_reg.uvl[EN_BIT] && state_reg.sync2[SYN_UV]
      |=> o_input_low_flag)
      else $error("input-low flag not set");

   a_uv_flag_clr: assert property (
      i_clk_en && !state_reg.sync2[SYN_UV] |=> !o_input_low_flag)
      else $error("input-low flag not cleared");

   a_uv_disabled: assert property (
      i_clk_en && !state_reg.uvl[EN_BIT] |=> !o_input_low_flag)
      else $error("input-low flag set while disabled");

   a_unimpl_zero: assert property (
      !state_reg.uvl[6] && !state_reg.acg[7] &&
      (state_reg.dcg[6:4] == 3'h0))
      else $error("unimplemented bit not zero");

   // Select may change mid-interval, so bound by the longest setting
   a_blank_bound: assert property (
      state_reg.state == DRV_BLANK |->
      state_reg.cnt != '0 && state_reg.cnt <= CNT_W'(BLANK3_CYC))
      else $error("blanking count out of range");

   a_blank_load: assert property (
      i_clk_en && pwm_rise &&
      (state_reg.state inside {DRV_OFF, DRV_TERM})
      |=> state_reg.state == DRV_BLANK &&
      state_reg.cnt == blank_cycles($past(state_reg.occ[BLANK_LSB +: 2])))
      else $error("blanking count not loaded");

   a_blank_quiet: assert property (
      state_reg.state == DRV_BLANK |=> state_reg.state != DRV_TERM)
      else $error("termination during blanking");

   a_sense_only: assert property (
      state_reg.state != DRV_SENSE |-> !oc_event)
      else $error("overcurrent judged outside conduction");

   a_pwm_end_off: assert property (
      i_clk_en && pwm_low &&
      (state_reg.state inside {DRV_BLANK, DRV_SENSE})
      |=> !o_hs_drive)
      else $error("drive kept after conduction end");

   a_clear_clean: assert property (
      i_clk_en && wr_flag_clr && state_reg.clean && !oc_event
      |=> !o_overcurrent_flag)
      else $error("overcurrent flag not cleared");

   a_rdata_upper: assert property (
      o_hrdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");

   a_freeze_hold: assert property (
      !i_clk_en |=> $stable(state_reg))
      else $error("state changed while clock enable low");

   a_oc_cut: assert property (
      i_clk_en && state_reg.state == DRV_SENSE && oc_hit && !pwm_low
      |=> !o_hs_drive && o_overcurrent_flag)
      else $error("overcurrent did not cut drive");

   a_rearm_drive: assert property (
      i_clk_en && state_reg.state == DRV_TERM && pwm_rise
      |=> o_hs_drive ##0 state_reg.state == DRV_BLANK)
      else $error("drive not restored at cycle start");

   a_clear_held: assert property (
      i_clk_en && wr_flag_clr && !state_reg.clean &&
      state_reg.oc_flag |=> o_overcurrent_flag)
      else $error("overcurrent flag cleared too early");

   a_oc_disabled: assert property (
      i_clk_en && !state_reg.occ[EN_BIT] &&
      state_reg.state != DRV_TERM |=> state_reg.state != DRV_TERM)
      else $error("termination while overcurrent disabled");

   a_oc_sticky: assert property (
      i_clk_en && state_reg.oc_flag && !wr_flag_clr
      |=> o_overcurrent_flag)
      else $error("overcurrent flag dropped by itself");

endmodule

// ---- verif/buck_fault_sense_config_bench.sv ----
`timescale 1ns/100ps
module buck_fault_sense_config_bench
   import buck_fault_pkg::*;
;
   // ****************
   // Signals
   // ****************
   logic           ref_clk    = 1'b0;
   logic           rst_n      = 1'b0;
   logic           clk_en     = 1'b1;
   logic           hsel       = 1'b0;
   logic [7:0]     haddr      = 8'h00;
   logic [1:0]     htrans     = 2'b00;
   logic           hwrite     = 1'b0;
   logic [2:0]     hsize      = 3'h0;
   logic [31:0]    hwdata     = 32'h0000_0000;
   logic [5:0]     vin_code   = 6'h3F;
   logic [9:0]     drop_mv    = 10'h000;
   logic [31:0]    hrdata;
   logic           hreadyout;
   logic           hresp;
   logic           vin_below;
   logic           oc_trip;
   logic           pwm_req;
   logic           hs_drive;
   logic           uv_flag;
   logic           oc_flag;
   analog_cfg_type cfg;
   int             err_total  = 0;
   int             n_compared = 0;

   always #25 ref_clk = ~ref_clk;

   buck_fault_sense_config i_dut (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_vin_below(vin_below), .i_oc_trip(oc_trip),
      .i_pwm_req(pwm_req), .o_cfg(cfg), .o_hs_drive(hs_drive),
      .o_input_low_flag(uv_flag), .o_overcurrent_flag(oc_flag));

   buck_stage_model i_stage (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cfg(cfg),
      .i_hs_drive(hs_drive), .i_vin_code(vin_code),
      .i_drop_mv(drop_mv), .o_vin_below(vin_below),
      .o_oc_trip(oc_trip), .o_pwm_req(pwm_req));

   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [2:0] sz, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= sz;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, HSIZE_WORD, rd);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0000_0000, HSIZE_WORD, rd);
      check(rd, exp);
   endtask

   // Waits for a fresh drive pulse and counts its length
   task automatic measure(output int hi);
      hi = 0;
      for (int k = 0; k < 99 && hs_drive === 1'b1; k++) @(posedge ref_clk);
      for (int k = 0; k < 99 && hs_drive !== 1'b1; k++) @(posedge ref_clk);
      while (hs_drive === 1'b1 && hi < 99) begin
         @(posedge ref_clk);
         hi++;
      end
   endtask

   task automatic t_reset;
      logic [31:0] rd;
      for (int i = 0; i < 4; i++) begin
         rd_chk(8'(4 * i), 32'h0000_0000);
      end
      // Drive state bit follows the running modulator
      bus(1'b0, OFS_FLAGS, 32'h0000_0000, HSIZE_WORD, rd);
      check(rd & 32'hFFFF_FFFB, 32'h0000_0000);
      check(32'(cfg), 32'h0000_0000);
      check(32'(hresp), 32'(HRESP_OKAY));
      check(32'(hreadyout), 32'h1);
   endtask

   task automatic t_freeze;
      vin_code <= 6'd10;
      wr(8'h00, 32'h0000_0094);
      repeat (6) @(posedge ref_clk);
      clk_en   <= 1'b0;
      vin_code <= 6'd30;
      repeat (8) @(posedge ref_clk);
      check(32'(uv_flag), 32'h1);
      clk_en <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check(32'(uv_flag), 32'h0);
      vin_code <= 6'd10;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      check(32'({hs_drive, uv_flag, oc_flag}), 32'h0);
      t_reset();
   endtask

   task automatic t_regs;
      logic [7:0]  addr [4];
      logic [7:0]  mask [4];
      logic [31:0] rd;
      addr = '{8'h00, 8'h04, 8'h08, 8'h0C};
      mask = '{8'hBF, 8'hFF, 8'h7F, 8'h8F};
      for (int i = 0; i < 4; i++) begin
         wr(addr[i], 32'hFFFF_FFFF);
         rd_chk(addr[i], 32'(mask[i]));
      end
      check(32'(cfg), 32'h07FF_FFFF);
      bus(1'b1, 8'h04, 32'h0000_0000, 3'h0, rd);
      rd_chk(8'h04, 32'h0000_00FF);
      wr(8'h20, 32'hFFFF_FFFF);
      rd_chk(8'h20, 32'h0000_0000);
      for (int c = 0; c < 32; c++) begin
         wr(8'h04, 32'({c[1:0], c[4:0]}));
         wr(8'h08, 32'(c));
         wr(8'h0C, {24'h0, c[3], 4'hF, c[2:0]});
         check(32'(cfg.oc_threshold), 32'(c[4:0]));
         check(32'(cfg.blanking_select), 32'(c[1:0]));
         check(32'(cfg.ac_gain_select), 32'(c[3:0]));
         rd_chk(8'h0C, {24'h0, c[3], 3'h0, 1'b1, c[2:0]});
         check(32'({cfg.dc_gain_route, cfg.dc_gain_select}),
               32'({c[3], c[2:0]}));
      end
      for (int i = 0; i < 4; i++) begin
         wr(addr[i], 32'h0000_0000);
      end
   endtask

   task automatic t_uv;
      logic [31:0] rd;
      vin_code <= 6'd10;
      wr(8'h00, 32'h0000_0014);
      repeat (6) @(posedge ref_clk);
      check(32'(uv_flag), 32'h0);
      wr(8'h00, 32'h0000_0094);
      repeat (6) @(posedge ref_clk);
      check(32'(uv_flag), 32'h1);
      bus(1'b0, 8'h10, 32'h0000_0000, HSIZE_WORD, rd);
      check(32'(rd[0]), 32'h1);
      vin_code <= 6'd30;
      repeat (2) @(posedge ref_clk);
      check(32'(uv_flag), 32'h1);
      repeat (4) @(posedge ref_clk);
      check(32'(uv_flag), 32'h0);
      wr(8'h00, 32'h0000_0000);
   endtask

   task automatic t_oc;
      int hi;
      int n;
      int ns [4];
      ns = '{114, 213, 400, 780};
      drop_mv <= 10'd500;
      for (int s = 0; s < 4; s++) begin
         n = (ns[s] + 49) / 50;
         wr(8'h04, 32'({1'b1, 2'(s), 5'h00}));
         measure(hi);
         measure(hi);
         check(32'(hi >= n && hi <= n + 3), 32'h1);
         check(32'(oc_flag), 32'h1);
         measure(hi);
         check(32'(hi >= n && hi <= n + 3), 32'h1);
      end
      wr(8'h10, 32'h0000_0002);
      @(posedge ref_clk);
      check(32'(oc_flag), 32'h1);
      drop_mv <= 10'd0;
      measure(hi);
      measure(hi);
      check(32'(oc_flag), 32'h1);
      wr(8'h10, 32'h0000_0002);
      @(posedge ref_clk);
      check(32'(oc_flag), 32'h0);
      wr(8'h04, 32'h0000_0000);
      drop_mv <= 10'd500;
      measure(hi);
      measure(hi);
      check(32'(hi > 25 && oc_flag === 1'b0), 32'h1);
      drop_mv <= 10'd400;
      wr(8'h04, 32'h0000_0090);
      measure(hi);
      measure(hi);
      check(32'(oc_flag), 32'h0);
      wr(8'h04, 32'h0000_008F);
      measure(hi);
      measure(hi);
      check(32'(oc_flag), 32'h1);
   endtask

   task automatic finish_test;
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_regs();
      t_uv();
      t_oc();
      t_freeze();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      finish_test();
   end
endmodule

// ---- verif/buck_stage_model.sv ----
`timescale 1ns/100ps
module buck_stage_model
   import buck_fault_pkg::*;
#(
   parameter int PERIOD = 40,
   parameter int ON_CYC = 30
)(
   // Clock and reset
   input  wire logic           i_ref_clk,
   input  wire logic           i_rst_n,
   // Settings and drive from the block
   input  wire analog_cfg_type i_cfg,
   input  wire logic           i_hs_drive,
   // Stage conditions
   input  wire logic [5:0]     i_vin_code,
   input  wire logic [9:0]     i_drop_mv,
   // Comparators and modulator
   output logic                o_vin_below,
   output logic                o_oc_trip,
   output logic                o_pwm_req
);
   // ****************
   // Comparators and modulator
   // ****************
   int cnt;
   assign o_vin_below = i_vin_code < i_cfg.uv_threshold;
   // Drop exists only while the high side conducts
   assign o_oc_trip = i_hs_drive &&
      (i_drop_mv > 10'd160 + 10'd15 * i_cfg.oc_threshold);
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         cnt       <= 0;
         o_pwm_req <= 1'b0;
      end else begin
         cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         o_pwm_req <= cnt < ON_CYC;
      end
   end
endmodule
